// ---- hdl/pwct_in_filter.sv ----
// Purpose: glitch filter and edge detector on the timer input
// Assumes: timer_input is synchronous to sys_clk
// Notes:   a level must persist for the full filter length before it passes
`timescale 1ns/10ps
module pwct_in_filter
  import pwct_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       timer_input,
  input  wire logic [1:0] filter_width_select,
  output logic            filt_q,
  output logic            rise_q,
  output logic            fall_q
);

  logic       raw_q;
  logic       raw_d;
  logic       filt_d;
  logic [4:0] run_q;
  logic [4:0] run_d;
  logic       rise_d;
  logic       fall_d;

  function automatic logic [4:0] filt_len(input logic [1:0] sel);
    case (sel)
      FILT_4:  filt_len = FILT_LEN_4;
      FILT_8:  filt_len = FILT_LEN_8;
      FILT_16: filt_len = FILT_LEN_16;
      default: filt_len = FILT_LEN_4;
    endcase
  endfunction

  always_comb begin
    raw_d  = timer_input;
    filt_d = filt_q;
    run_d  = FILT_RUN_RESET;
    if (filter_width_select == FILT_OFF) begin
      filt_d = raw_q;
    end else if (raw_q != filt_q) begin
      // a pulse shorter than the length restarts the count and never passes
      if (run_q == filt_len(filter_width_select) - 5'h01) begin
        filt_d = raw_q;
      end else begin
        run_d = run_q + 5'h01;
      end
    end
    rise_d = filt_d & ~filt_q;
    fall_d = ~filt_d & filt_q;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      raw_q  <= 1'b0;
      filt_q <= 1'b0;
      run_q  <= FILT_RUN_RESET;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      raw_q  <= raw_d;
      filt_q <= filt_d;
      run_q  <= run_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

endmodule

// ---- hdl/pwct_pkg.sv ----
// Purpose: shared constants and types of the pwm output / input capture timer
// Assumes: 100 MHz system clock
// Notes:   not every reset value lives here, only the counter, divider, filter-run and flag reset values
package pwct_pkg;

  localparam int unsigned SYS_CLK_MHZ   = 100;
  localparam int unsigned FAST_TICK_MHZ = 48;

  // fractional accumulator that derives the 48 MHz capture tick from sys_clk
  localparam logic [7:0] FAST_ACC_STEP = 8'(FAST_TICK_MHZ);
  localparam logic [7:0] FAST_ACC_WRAP = 8'(SYS_CLK_MHZ);

  localparam int unsigned CNT_W     = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;

  localparam int unsigned PSC_W     = 3;
  localparam int unsigned PSC_CNT_W = 7;
  localparam logic [6:0]  PSC_RESET = 7'h00;

  localparam logic [1:0] FILT_OFF   = 2'h0;
  localparam logic [1:0] FILT_4     = 2'h1;
  localparam logic [1:0] FILT_8     = 2'h2;
  localparam logic [1:0] FILT_16    = 2'h3;
  localparam logic [4:0] FILT_LEN_4  = 5'h04;
  localparam logic [4:0] FILT_LEN_8  = 5'h08;
  localparam logic [4:0] FILT_LEN_16 = 5'h10;
  localparam logic [4:0] FILT_RUN_RESET = 5'h00;

  localparam int unsigned FLAG_W      = 3;
  localparam int unsigned FLAG_MATCH  = 0;
  localparam int unsigned FLAG_PERIOD = 1;
  localparam int unsigned FLAG_OVF    = 2;
  localparam logic [2:0]  FLAG_RESET  = 3'h0;

  localparam logic MODE_CAPTURE = 1'b0;
  localparam logic MODE_OUTPUT  = 1'b1;

  typedef enum logic [0:0] {
    CAP_WAIT = 1'b0,
    CAP_MEAS = 1'b1
  } pwct_cap_state_t;

endpackage

// ---- hdl/pwct_prescaler.sv ----
// Purpose: counter tick generator, divide by 1..128 or a 48 MHz capture rate
// Assumes: prescale_select is changed only while the counter is stopped
// Notes:   the divider runs free, so a new setting acts on the very next tick
`timescale 1ns/10ps
module pwct_prescaler
  import pwct_pkg::*;
#(
  parameter bit FAST_ENABLE = 1'b1
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [PSC_W-1:0] prescale_select,
  input  wire logic             fast_sel,
  output logic                  tick_q
);

  logic [PSC_CNT_W-1:0] div_q;
  logic [PSC_CNT_W-1:0] div_d;
  logic [7:0]           acc_q;
  logic [7:0]           acc_d;
  logic                 tick_d;

  function automatic logic [PSC_CNT_W-1:0] psc_mask(input logic [PSC_W-1:0] sel);
    logic [7:0] one_hot;
    one_hot  = 8'h01 << sel;
    psc_mask = PSC_CNT_W'(one_hot - 8'h01);
  endfunction

  always_comb begin
    logic [7:0] sum;
    logic       fast_hit;
    sum      = acc_q + FAST_ACC_STEP;
    fast_hit = 1'b0;
    acc_d    = sum;
    if (sum >= FAST_ACC_WRAP) begin
      acc_d    = sum - FAST_ACC_WRAP;
      fast_hit = 1'b1;
    end
    div_d = div_q + 7'h01;
    // unbuffered selection: the mask is taken straight from the port
    if (FAST_ENABLE && fast_sel) begin
      tick_d = fast_hit;
    end else begin
      tick_d = (div_q & psc_mask(prescale_select)) == psc_mask(prescale_select);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q  <= PSC_RESET;
      acc_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

endmodule

// ---- hdl/pwct_timer.sv ----
// Purpose: 16-bit pwm output / input capture timer with prescaler and filter
// Assumes: software-side strobes are one-cycle pulses synchronous to sys_clk
// Notes:   all software access is by plain ports, no bus
`timescale 1ns/10ps
module pwct_timer
  import pwct_pkg::*;
#(
  parameter bit FAST_ENABLE = 1'b1
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [PSC_W-1:0]  prescale_select,
  input  wire logic              mode_select,
  input  wire logic              polarity_edge_select,
  input  wire logic              single_shot,
  input  wire logic [1:0]        filter_width_select,
  input  wire logic              match_width_irq_en,
  input  wire logic              period_irq_en,
  input  wire logic              overflow_irq_en,
  input  wire logic              shared_fast_select,
  input  wire logic              timer_input,
  input  wire logic              run_wr,
  input  wire logic              run_wr_data,
  input  wire logic              count_wr,
  input  wire logic [CNT_W-1:0]  count_wr_data,
  input  wire logic              compare_wr,
  input  wire logic [CNT_W-1:0]  compare_wr_data,
  input  wire logic              reload_wr,
  input  wire logic [CNT_W-1:0]  reload_wr_data,
  input  wire logic              flag_wr,
  input  wire logic [FLAG_W-1:0] flag_wr_data,
  input  wire logic              count_hi_rd,
  output logic                   run_enable_q,
  output logic [CNT_W-1:0]       base_count_q,
  output logic [CNT_W-1:0]       compare_capture_width_q,
  output logic [CNT_W-1:0]       reload_capture_period_q,
  output logic                   match_width_flag_q,
  output logic                   period_detect_flag_q,
  output logic                   overflow_flag_q,
  output logic [7:0]             count_hi_data_q,
  output logic [7:0]             count_lo_data_q,
  output logic                   irq_q,
  output logic                   pwm_out_q
);

  logic              tick;
  logic              filt;
  logic              rise;
  logic              fall;
  logic              fast_sel;
  logic              period_edge;
  logic              width_edge;
  logic              run_d;
  logic [CNT_W-1:0]  count_d;
  logic [CNT_W-1:0]  compare_d;
  logic [CNT_W-1:0]  reload_d;
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] irq_en;
  logic [7:0]        hi_d;
  logic [7:0]        lo_d;
  logic              irq_d;
  logic              pwm_d;
  pwct_cap_state_t   cap_q;
  pwct_cap_state_t   cap_d;

  assign fast_sel    = shared_fast_select && (mode_select == MODE_CAPTURE);
  assign period_edge = polarity_edge_select ? fall : rise;
  assign width_edge  = polarity_edge_select ? rise : fall;
  assign irq_en      = {overflow_irq_en, period_irq_en, match_width_irq_en};

  pwct_prescaler #(
    .FAST_ENABLE(FAST_ENABLE)
  ) u_psc (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .prescale_select(prescale_select),
    .fast_sel       (fast_sel),
    .tick_q         (tick)
  );

  pwct_in_filter u_filt (
    .sys_clk            (sys_clk),
    .sys_rst            (sys_rst),
    .timer_input        (timer_input),
    .filter_width_select(filter_width_select),
    .filt_q             (filt),
    .rise_q             (rise),
    .fall_q             (fall)
  );

  // counter, capture registers, run enable and event flags
  always_comb begin
    run_d     = run_enable_q;
    count_d   = base_count_q;
    compare_d = compare_capture_width_q;
    reload_d  = reload_capture_period_q;
    cap_d     = cap_q;
    flag_set  = FLAG_RESET;
    if (compare_wr) begin
      compare_d = compare_wr_data;
    end
    if (reload_wr) begin
      reload_d = reload_wr_data;
    end
    if (run_enable_q) begin
      if (mode_select == MODE_OUTPUT) begin
        if (tick) begin
          if (base_count_q == compare_capture_width_q) begin
            flag_set[FLAG_MATCH] = 1'b1;
          end
          if (base_count_q == reload_capture_period_q) begin
            flag_set[FLAG_OVF] = 1'b1;
            count_d            = CNT_RESET;
            if (single_shot) begin
              run_d = 1'b0;
            end
          end else begin
            count_d = base_count_q + 16'h0001;
          end
        end
      end else begin
        if (period_edge) begin
          if (cap_q == CAP_MEAS) begin
            reload_d              = base_count_q;
            flag_set[FLAG_PERIOD] = 1'b1;
            if (single_shot) begin
              run_d = 1'b0;
            end
          end
          count_d = CNT_RESET;
          cap_d   = CAP_MEAS;
        end else if (tick) begin
          if (base_count_q == CNT_MAX) begin
            flag_set[FLAG_OVF] = 1'b1;
            count_d            = CNT_RESET;
            if (single_shot) begin
              run_d = 1'b0;
            end
          end else begin
            count_d = base_count_q + 16'h0001;
          end
        end
        // the width is only meaningful once a period-starting edge was seen
        if (width_edge && cap_q == CAP_MEAS) begin
          compare_d            = base_count_q;
          flag_set[FLAG_MATCH] = 1'b1;
        end
      end
    end
    if (!run_d) begin
      cap_d = CAP_WAIT;
    end
    // software write of the count wins; software is expected to stop first
    if (count_wr) begin
      count_d = count_wr_data;
    end
    // a hardware stop outranks a software run write in the same cycle
    if (run_wr && (run_d == run_enable_q)) begin
      run_d = run_wr_data;
    end
    flags_d = flags_q;
    if (flag_wr) begin
      flags_d = flags_q & flag_wr_data;
    end
    flags_d = flags_d | flag_set;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_enable_q            <= 1'b0;
      base_count_q            <= CNT_RESET;
      compare_capture_width_q <= CNT_RESET;
      reload_capture_period_q <= CNT_RESET;
      flags_q                 <= FLAG_RESET;
      cap_q                   <= CAP_WAIT;
    end else begin
      run_enable_q            <= run_d;
      base_count_q            <= count_d;
      compare_capture_width_q <= compare_d;
      reload_capture_period_q <= reload_d;
      flags_q                 <= flags_d;
      cap_q                   <= cap_d;
    end
  end

  assign match_width_flag_q   = flags_q[FLAG_MATCH];
  assign period_detect_flag_q = flags_q[FLAG_PERIOD];
  assign overflow_flag_q      = flags_q[FLAG_OVF];

  // output pin, interrupt and count read latch
  always_comb begin
    hi_d  = count_hi_data_q;
    lo_d  = count_lo_data_q;
    irq_d = |(flags_q & irq_en);
    pwm_d = 1'b0;
    if (mode_select == MODE_OUTPUT) begin
      // compare == reload keeps count <= compare all period, a constant level
      pwm_d = (base_count_q <= compare_capture_width_q) ? polarity_edge_select
                                                        : ~polarity_edge_select;
    end
    if (count_hi_rd) begin
      hi_d = base_count_q[15:8];
      lo_d = base_count_q[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_hi_data_q <= 8'h00;
      count_lo_data_q <= 8'h00;
      irq_q           <= 1'b0;
      pwm_out_q       <= 1'b0;
    end else begin
      count_hi_data_q <= hi_d;
      count_lo_data_q <= lo_d;
      irq_q           <= irq_d;
      pwm_out_q       <= pwm_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence out_tick_s;
    run_enable_q && mode_select == MODE_OUTPUT && tick && !count_wr && !run_wr;
  endsequence

  sequence cap_period_s;
    run_enable_q && mode_select == MODE_CAPTURE && period_edge && cap_q == CAP_MEAS
      && !count_wr && !reload_wr && !run_wr;
  endsequence

  pwm_level_a: assert property (
    mode_select == MODE_OUTPUT && $stable(mode_select) |=>
      pwm_out_q == ($past(base_count_q) <= $past(compare_capture_width_q)
                    ? $past(polarity_edge_select) : !$past(polarity_edge_select)))
    else $error("pwm level does not follow count against compare");

  out_reload_a: assert property (
    out_tick_s ##0 (base_count_q == reload_capture_period_q) |=>
      base_count_q == CNT_RESET && overflow_flag_q)
    else $error("reload match did not clear count and set overflow");

  oneshot_stop_a: assert property (
    out_tick_s ##0 (base_count_q == reload_capture_period_q && single_shot) |=>
      !run_enable_q ##1 !run_enable_q)
    else $error("single shot did not stop the timer");

  match_flag_a: assert property (
    out_tick_s ##0 (base_count_q == compare_capture_width_q
                    && base_count_q != reload_capture_period_q) |=>
      match_width_flag_q && base_count_q == $past(base_count_q) + 16'h0001)
    else $error("compare match flag or continued count missing");

  width_cap_a: assert property (
    run_enable_q && mode_select == MODE_CAPTURE && width_edge && cap_q == CAP_MEAS
      && !compare_wr |=>
      compare_capture_width_q == $past(base_count_q) && match_width_flag_q)
    else $error("width capture wrong");

  period_cap_a: assert property (
    cap_period_s |=> reload_capture_period_q == $past(base_count_q)
      && period_detect_flag_q && base_count_q == CNT_RESET)
    else $error("period capture wrong");

  cap_ovf_a: assert property (
    run_enable_q && mode_select == MODE_CAPTURE && !period_edge && tick
      && base_count_q == CNT_MAX && !count_wr |=>
      overflow_flag_q && base_count_q == CNT_RESET)
    else $error("capture overflow not handled");

  flag_sticky_a: assert property (
    overflow_flag_q && !(flag_wr && !flag_wr_data[FLAG_OVF]) |=> overflow_flag_q)
    else $error("overflow flag dropped without a zero write");

  irq_follow_a: assert property (
    ##1 irq_q == $past(|(flags_q & irq_en)))
    else $error("interrupt request does not follow enabled flags");

  count_hold_a: assert property (
    (!run_enable_q && !count_wr) [*2] |-> $stable(base_count_q))
    else $error("count moved while stopped");

  read_latch_a: assert property (
    count_hi_rd |=> count_lo_data_q == $past(base_count_q[7:0])
      && count_hi_data_q == $past(base_count_q[15:8]))
    else $error("low byte not latched on high read");

endmodule

// ---- test/pwct_pwm_src.sv ----
// Purpose: pwm source standing in for the external signal on the timer input
// Assumes: phase lengths are counted in sys_clk cycles and are at least one
// Notes:   idles low while disabled and always opens with a low phase
`timescale 1ns/10ps
module pwct_pwm_src (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        src_en,
  input  wire logic [15:0] high_len,
  input  wire logic [15:0] low_len,
  output logic             src_out_q
);
  logic [15:0] run_q;
  logic [15:0] run_d;
  logic        out_d;

  always_comb begin
    run_d = run_q + 16'h0001;
    out_d = src_out_q;
    if (!src_en) begin
      run_d = 16'h0000;
      out_d = 1'b0;
    end else if (run_d >= (src_out_q ? high_len : low_len)) begin
      // phase complete: flip the level so each phase lasts exactly its length
      run_d = 16'h0000;
      out_d = ~src_out_q;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q     <= 16'h0000;
      src_out_q <= 1'b0;
    end else begin
      run_q     <= run_d;
      src_out_q <= out_d;
    end
  end
endmodule

// ---- test/pwct_timer_tb_top.sv ----
// Purpose: self-checking bench for the pwm output / input capture timer
// Assumes: software access is modelled by one-cycle strobes at the rising edge
// Notes:   outputs are sampled on the falling edge, clear of update races
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pwct_timer_tb_top;
  import pwct_pkg::*;
  logic             sys_clk              = 1'b0;
  logic             sys_rst              = 1'b1;
  logic [PSC_W-1:0] prescale_select      = 3'h0;
  logic             mode_select          = 1'b0;
  logic             polarity_edge_select = 1'b0;
  logic             single_shot          = 1'b0;
  logic [1:0]       filter_width_select  = 2'h0;
  logic [2:0]       ien                  = 3'h0;
  logic             shared_fast_select   = 1'b0;
  logic             tb_in                = 1'b0;
  logic             src_sel              = 1'b0;
  logic             src_en               = 1'b0;
  logic [15:0]      high_len             = 16'h0007;
  logic [15:0]      low_len              = 16'h000C;
  logic [5:0]       strb                 = 6'h00;
  logic [15:0]      wdat                 = 16'h0000;
  logic             src_out_q;
  wire logic        timer_input          = src_sel ? src_out_q : tb_in;
  logic             run_enable_q;
  logic             match_width_flag_q;
  logic             period_detect_flag_q;
  logic             overflow_flag_q;
  logic             irq_q;
  logic             pwm_out_q;
  logic [15:0]      base_count_q;
  logic [15:0]      compare_capture_width_q;
  logic [15:0]      reload_capture_period_q;
  logic [7:0]       count_hi_data_q;
  logic [7:0]       count_lo_data_q;
  logic [15:0]      c;
  logic             p;
  int               miscompares = 0;
  int               cmp_count   = 0;
  int               cyc         = 0;
  int               i, n, k, w, d0;
  int               rl[6]       = '{4, 4, 4, 4, 4, 5};
  int               cp[6]       = '{1, 1, 4, 4, 0, 0};

  pwct_timer u_dut (
    .sys_clk, .sys_rst, .prescale_select, .mode_select, .polarity_edge_select,
    .single_shot, .filter_width_select, .match_width_irq_en(ien[0]),
    .period_irq_en(ien[1]), .overflow_irq_en(ien[2]), .shared_fast_select, .timer_input,
    .run_wr(strb[0]), .run_wr_data(wdat[0]), .count_wr(strb[1]), .count_wr_data(wdat),
    .compare_wr(strb[2]), .compare_wr_data(wdat), .reload_wr(strb[3]),
    .reload_wr_data(wdat), .flag_wr(strb[4]), .flag_wr_data(wdat[2:0]),
    .count_hi_rd(strb[5]), .run_enable_q, .base_count_q, .compare_capture_width_q,
    .reload_capture_period_q, .match_width_flag_q, .period_detect_flag_q,
    .overflow_flag_q, .count_hi_data_q, .count_lo_data_q, .irq_q, .pwm_out_q
  );

  pwct_pwm_src u_src (.sys_clk, .sys_rst, .src_en, .high_len, .low_len, .src_out_q);

  always #5 sys_clk = ~sys_clk;

  // the whole sequence needs well under two thousand cycles; this only catches a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  // wr: 0 run, 1 count, 2 compare, 3 reload, 4 flags, 5 high-byte read
  task automatic wr(input int s, input logic [15:0] d);
    @(posedge sys_clk);
    strb <= 6'h01 << s;
    wdat <= d;
    @(posedge sys_clk);
    strb <= 6'h00;
  endtask

  task automatic nc(input int m);
    repeat (m) @(negedge sys_clk);
  endtask

  task automatic cfg(input logic m, input logic pl, input logic s, input logic [2:0] ps,
                     input logic clr);
    wr(0, 16'h0000);
    mode_select          <= m;
    polarity_edge_select <= pl;
    single_shot          <= s;
    prescale_select      <= ps;
    wr(1, 16'h0000);
    if (clr) begin
      wr(4, 16'h0000);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    nc(1);
    `CHK({run_enable_q, base_count_q, irq_q, pwm_out_q}, 19'h00000)
    `CHK({match_width_flag_q, period_detect_flag_q, overflow_flag_q}, 3'h0)
    wr(1, 16'hA5C3);
    nc(1);
    `CHK(base_count_q, 16'hA5C3)
    wr(5, 16'h0000);
    wr(1, 16'h1234);
    nc(1);
    `CHK({count_hi_data_q, count_lo_data_q}, 16'hA5C3)
    // tick spacing for every divide code, stopped while the code changes
    cfg(1'b1, 1'b0, 1'b0, 3'h0, 1'b1);
    wr(3, 16'hFFFF);
    wr(2, 16'hFFFF);
    for (k = 0; k < 8; k++) begin
      wr(0, 16'h0000);
      prescale_select <= 3'(k);
      wr(0, 16'h0001);
      nc(1);
      for (i = 0; i < 2; i++) begin
        c = base_count_q;
        for (n = 0; n < 300 && base_count_q === c; n++) nc(1);
      end
      `CHK(n, 1 << k)
    end
    // pwm: plain duty, compare equal to reload, compare zero, both polarities
    for (k = 0; k < 6; k++) begin
      p = 1'(k);
      cfg(1'b1, p, 1'b0, 3'h0, 1'b1);
      wr(3, 16'(rl[k]));
      wr(2, 16'(cp[k]));
      wr(0, 16'h0001);
      nc(1);
      for (i = 0; i < 20; i++) begin
        c = base_count_q;
        nc(1);
        `CHK(pwm_out_q, (c <= 16'(cp[k])) ? p : ~p)
        `CHK(base_count_q, (c == 16'(rl[k])) ? 16'h0000 : c + 16'h0001)
      end
      `CHK({overflow_flag_q, match_width_flag_q}, 2'h3)
    end
    wr(0, 16'h0000);
    wr(4, 16'h0007);
    nc(1);
    `CHK({overflow_flag_q, match_width_flag_q}, 2'h3)
    wr(4, 16'h0006);
    nc(1);
    `CHK({overflow_flag_q, match_width_flag_q}, 2'h2)
    cfg(1'b1, 1'b0, 1'b1, 3'h0, 1'b1);
    wr(3, 16'h0003);
    wr(0, 16'h0001);
    nc(1);
    for (n = 0; n < 20 && run_enable_q === 1'b1; n++) nc(1);
    nc(4);
    `CHK({run_enable_q, base_count_q, overflow_flag_q}, 18'h00001)
    // fast capture tick against the slowest divider over 100 cycles
    for (k = 1; k >= 0; k--) begin
      cfg(1'b0, 1'b0, 1'b0, 3'h7, 1'b0);
      shared_fast_select <= 1'(k);
      wr(0, 16'h0001);
      nc(100);
      wr(0, 16'h0000);
      nc(1);
      c = k ? 16'h002E : 16'h0000;
      `CHK(base_count_q inside {[c : c + (k ? 16'h0004 : 16'h0001)]}, 1'b1)
    end
    // filter: a pulse one short of the length is lost, the lag grows by one less than the length
    for (k = 0; k < 4; k++) begin
      w = k ? 2 << k : 0;
      cfg(1'b0, 1'b0, 1'b0, 3'h0, 1'b1);
      filter_width_select <= 2'(k);
      wr(0, 16'h0001);
      if (k) begin
        tb_in <= 1'b1;
        repeat (w - 1) @(posedge sys_clk);
        tb_in <= 1'b0;
        nc(w + 8);
        `CHK({match_width_flag_q, period_detect_flag_q}, 2'h0)
      end
      @(posedge sys_clk);
      tb_in <= 1'b1;
      for (i = 0; i < 40; i++) begin
        c = base_count_q;
        nc(1);
        if (base_count_q < c) break;
      end
      // lag against the synchronised input is one cycle more than this difference
      if (k == 0) d0 = i;
      else `CHK((i - d0 + 1) inside {[w : w + 1]}, 1'b1)
      @(posedge sys_clk);
      tb_in <= 1'b0;
      nc(w + 6);
      `CHK(match_width_flag_q, 1'b1)
    end
    // capture of a 7 high / 12 low waveform on both edge selections
    for (k = 0; k < 2; k++) begin
      cfg(1'b0, 1'(k), 1'(k), 3'h0, 1'b1);
      // the 7-cycle phase would never pass the 16-clock filter left from above
      filter_width_select <= FILT_OFF;
      src_sel             <= 1'b1;
      wr(0, 16'h0001);
      src_en <= 1'b1;
      for (i = 0; i < 200 && period_detect_flag_q !== 1'b1; i++) nc(1);
      nc(3);
      c = reload_capture_period_q - compare_capture_width_q;
      `CHK(c, k ? 16'h0007 : 16'h000C)
      `CHK(reload_capture_period_q inside {16'h0012, 16'h0013}, 1'b1)
      `CHK(run_enable_q, ~1'(k))
      @(posedge sys_clk);
      src_en <= 1'b0;
    end
    src_sel <= 1'b0;
    cfg(1'b0, 1'b0, 1'b1, 3'h0, 1'b0);
    wr(1, 16'hFFF0);
    wr(0, 16'h0001);
    nc(30);
    `CHK({run_enable_q, base_count_q, overflow_flag_q}, 18'h00001)
    // all three flags stand now: mask them one by one, then clear them
    for (k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      ien <= (k < 3) ? 3'h1 << k : 3'h0;
      nc(3);
      `CHK(irq_q, 1'(k < 3))
    end
    @(posedge sys_clk);
    ien <= 3'h7;
    for (k = 1; k < 4; k++) begin
      wr(4, 16'(3'h7 << k));
      nc(3);
      `CHK(irq_q, 1'(k < 3))
    end
    conclude();
  end
endmodule
